// ===== shared/fmc_consts.svh
`ifndef FMC_CONSTS_SVH
`define FMC_CONSTS_SVH

// Register indices; byte address is four times the index
`define FMC_IDX_ENABLE     6'h01
`define FMC_IDX_DROOP      6'h02
`define FMC_IDX_FLASH1     6'h03
`define FMC_IDX_FLASH2     6'h04
`define FMC_IDX_TORCH1     6'h05
`define FMC_IDX_TORCH2     6'h06
`define FMC_IDX_BOOST      6'h07
`define FMC_IDX_TIMING     6'h08
`define FMC_IDX_FAULT_FLAGS_FIRST     6'h0a
`define FMC_IDX_FAULT_FLAGS_SECOND     6'h0b

// Reset values
`define FMC_RST_ENABLE     8'h80
`define FMC_RST_DROOP      8'h00
`define FMC_RST_FLASH      8'h00
`define FMC_RST_TORCH      8'h00
`define FMC_RST_BOOST      8'h00
`define FMC_RST_TIMING     8'h1a

// Enable register fields
`define FMC_EN_TX_BIT      7
`define FMC_EN_STROBE_BIT  5
`define FMC_EN_TORCH_BIT   4
`define FMC_EN_MODE_HI     3
`define FMC_EN_MODE_LO     2
`define FMC_MODE_STANDBY   2'b00
`define FMC_MODE_IR        2'b01
`define FMC_MODE_TORCH     2'b10
`define FMC_MODE_FLASH     2'b11

// Droop, boost and timing fields
`define FMC_DROOP_THR_HI   5
`define FMC_DROOP_THR_LO   3
`define FMC_DROOP_HYST_BIT 2
`define FMC_BOOST_SWRST    7
`define FMC_BOOST_PASS     2
`define FMC_BOOST_FREQ     1
`define FMC_BOOST_ILIM     0
`define FMC_TIM_RAMP_HI    6
`define FMC_TIM_RAMP_LO    4
`define FMC_TIM_TOUT_HI    3
`define FMC_TIM_TOUT_LO    0

// Timing
`define FMC_CLK_PERIOD_NS  10
`define FMC_MS_NS          1000000
`define FMC_MS_CYCLES      (`FMC_MS_NS / `FMC_CLK_PERIOD_NS)
`define FMC_RAMP_BASE_NS   1000
`define FMC_RAMP_BASE_CYC  ((`FMC_RAMP_BASE_NS + `FMC_CLK_PERIOD_NS - 1) / `FMC_CLK_PERIOD_NS)
`define FMC_TOUT_MIN_MS    11'd40
`define FMC_TOUT_STEP_MS   11'd104

// Bus answers
`define FMC_RESP_OKAY      2'b00
`define FMC_RESP_SLVERR    2'b10

`endif

// ===== shared/fmc_pkg.sv
`default_nettype none
package fmc_pkg;
	typedef enum logic [3:0] {
		fmc_st_standby = 4'b0001,
		fmc_st_torch   = 4'b0010,
		fmc_st_flash   = 4'b0100,
		fmc_st_ir      = 4'b1000
	} fmc_state_t;

	// Current code plus the range it is scaled in
	typedef struct packed {
		logic [7:0] code;
		logic       flash_scale;
	} fmc_led_t;
endpackage
`default_nettype wire

// ===== verilog/fmc_sync2.sv
`default_nettype none
module fmc_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_reg;

	// Two stages; the first is read by the second only
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_reg <= '0;
			q_out    <= '0;
		end else begin
			meta_reg <= d_in;
			q_out    <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/fmc_ramp.sv
`default_nettype none
module fmc_ramp
	import fmc_pkg::*;
(
	input  wire logic     clk_in,
	input  wire logic     rst_in,
	input  wire logic     active_in,
	input  wire logic     jump_in,
	input  wire logic     hold_in,
	input  wire logic     step_in,
	input  wire fmc_led_t target_in,
	output fmc_led_t      led_out
);
	// Current code steps one level per tick; a lower target is taken at once
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			led_out <= '0;
		end else if (!active_in) begin
			led_out <= '0;
		end else if (jump_in) begin
			led_out <= target_in;
		end else if (hold_in) begin
			led_out <= led_out;
		end else if (led_out.code > target_in.code) begin
			led_out <= target_in;
		end else if (step_in && led_out.code < target_in.code) begin
			led_out.code        <= led_out.code + 8'h01;
			led_out.flash_scale <= target_in.flash_scale;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/fmc_top.sv
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`default_nettype none
`include "fmc_consts.svh"
module fmc_top
	import fmc_pkg::*;
#(
	parameter int MS_CYCLES        = `FMC_MS_CYCLES,
	parameter int RAMP_BASE_CYCLES = `FMC_RAMP_BASE_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	output logic      [1:0]  s_axi_bresp_out,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	input  wire logic [7:0]  s_axi_araddr_in,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	output logic      [31:0] s_axi_rdata_out,
	output logic      [1:0]  s_axi_rresp_out,
	input  wire logic        trigger_pin_in,
	input  wire logic        sync_pin_in,
	input  wire logic        por_below_in,
	input  wire logic        droop_below_in,
	output fmc_led_t  [1:0]  led_out,
	output logic             boost_on_out,
	output logic             pass_only_out,
	output logic      [2:0]  droop_threshold_out,
	output logic             droop_hyst_out,
	output logic             freq_high_out,
	output logic             ilim_high_out
);
	logic [7:0] enable_reg, droop_reg, boost_reg, timing_reg;
	logic [7:0] flash_reg [2];
	logic [7:0] torch_reg [2];
	logic       flag_tout_reg, flag_droop_reg, swrst_reg, pass_only_reg, ext_reg;
	logic       aw_hold_reg, w_hold_reg, hold_reg, trig_d_reg, droop_d_reg;
	logic [5:0] aw_idx_reg;
	logic [7:0] w_data_reg;
	logic       w_lane_reg;
	logic [3:0] pins_s;
	logic       trig_s, sync_s, por_s, droop_s, trig_rise, droop_rise;
	logic       soft_clr, do_write, wr_ok, rd_take, rd_clr1, rd_clr2;
	logic [5:0] rd_idx;
	logic [1:0] mode;
	fmc_state_t state_reg, state_next;
	logic       run_tout, tout_hit, tout_event, tx_force, ramp_step;
	logic [31:0] ms_pre_reg;
	logic [10:0] ms_cnt_reg, tout_ms;
	logic [15:0] ramp_cnt_reg, ramp_period;
	logic       scale_d_reg;

	// Register index decode, shared by write and read paths
	function automatic logic reg_mapped(input logic [5:0] idx);
		case (idx)
			`FMC_IDX_ENABLE, `FMC_IDX_DROOP, `FMC_IDX_FLASH1, `FMC_IDX_FLASH2,
			`FMC_IDX_TORCH1, `FMC_IDX_TORCH2, `FMC_IDX_BOOST, `FMC_IDX_TIMING,
			`FMC_IDX_FAULT_FLAGS_FIRST, `FMC_IDX_FAULT_FLAGS_SECOND: reg_mapped = 1'b1;
			default: reg_mapped = 1'b0;
		endcase
	endfunction

	// Pins cross into the clock domain before any edge or level logic
	fmc_sync2 #(
		.W(4)
	) u_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.d_in  ({droop_below_in, por_below_in, sync_pin_in, trigger_pin_in}),
		.q_out (pins_s)
	);

	assign trig_s     = pins_s[0];
	assign sync_s     = pins_s[1];
	assign por_s      = pins_s[2];
	assign droop_s    = pins_s[3];
	assign trig_rise  = trig_s & ~trig_d_reg;
	assign droop_rise = droop_s & ~droop_d_reg;

	// Power-on level and software reset both clear the logic synchronously
	assign soft_clr = por_s | swrst_reg;

	// Edge detectors
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			trig_d_reg  <= 1'b0;
			droop_d_reg <= 1'b0;
		end else begin
			trig_d_reg  <= trig_s;
			droop_d_reg <= droop_s;
		end
	end

	// Write channels are taken independently; response follows both
	assign s_axi_awready_out = ~aw_hold_reg & ~s_axi_bvalid_out;
	assign s_axi_wready_out  = ~w_hold_reg & ~s_axi_bvalid_out;
	assign do_write          = aw_hold_reg & w_hold_reg & ~s_axi_bvalid_out;
	assign wr_ok             = do_write & reg_mapped(aw_idx_reg) & w_lane_reg;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			aw_hold_reg      <= 1'b0;
			w_hold_reg       <= 1'b0;
			aw_idx_reg       <= 6'h00;
			w_data_reg       <= 8'h00;
			w_lane_reg       <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= `FMC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_hold_reg <= 1'b1;
				aw_idx_reg  <= s_axi_awaddr_in[7:2];
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata_in[7:0];
				w_lane_reg <= s_axi_wstrb_in[0];
			end
			if (do_write) begin
				aw_hold_reg      <= 1'b0;
				w_hold_reg       <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= reg_mapped(aw_idx_reg) ? `FMC_RESP_OKAY : `FMC_RESP_SLVERR;
			end else if (s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// Read path; data registered one cycle after the address is taken
	assign s_axi_arready_out = ~s_axi_rvalid_out;
	assign rd_take           = s_axi_arvalid_in & s_axi_arready_out;
	assign rd_idx            = s_axi_araddr_in[7:2];
	assign rd_clr1           = rd_take & (rd_idx == `FMC_IDX_FAULT_FLAGS_FIRST);
	assign rd_clr2           = rd_take & (rd_idx == `FMC_IDX_FAULT_FLAGS_SECOND);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out  <= 32'h0000_0000;
			s_axi_rresp_out  <= `FMC_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rresp_out  <= reg_mapped(rd_idx) ? `FMC_RESP_OKAY : `FMC_RESP_SLVERR;
			case (rd_idx)
				`FMC_IDX_ENABLE: s_axi_rdata_out <= {24'h000000, enable_reg};
				`FMC_IDX_DROOP:  s_axi_rdata_out <= {24'h000000, droop_reg};
				`FMC_IDX_FLASH1: s_axi_rdata_out <= {24'h000000, flash_reg[0]};
				`FMC_IDX_FLASH2: s_axi_rdata_out <= {24'h000000, flash_reg[1]};
				`FMC_IDX_TORCH1: s_axi_rdata_out <= {24'h000000, torch_reg[0]};
				`FMC_IDX_TORCH2: s_axi_rdata_out <= {24'h000000, torch_reg[1]};
				`FMC_IDX_BOOST:  s_axi_rdata_out <= {24'h000000, boost_reg};
				`FMC_IDX_TIMING: s_axi_rdata_out <= {24'h000000, timing_reg};
				`FMC_IDX_FAULT_FLAGS_FIRST: s_axi_rdata_out <= {31'h0000_0000, flag_tout_reg};
				`FMC_IDX_FAULT_FLAGS_SECOND: s_axi_rdata_out <= {31'h0000_0000, flag_droop_reg};
				default:         s_axi_rdata_out <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

	// Configuration registers; the timeout clear is applied last so it wins
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			enable_reg   <= `FMC_RST_ENABLE;
			droop_reg    <= `FMC_RST_DROOP;
			flash_reg[0] <= `FMC_RST_FLASH;
			flash_reg[1] <= `FMC_RST_FLASH;
			torch_reg[0] <= `FMC_RST_TORCH;
			torch_reg[1] <= `FMC_RST_TORCH;
			boost_reg    <= `FMC_RST_BOOST;
			timing_reg   <= `FMC_RST_TIMING;
		end else if (soft_clr) begin
			enable_reg   <= `FMC_RST_ENABLE;
			droop_reg    <= `FMC_RST_DROOP;
			flash_reg[0] <= `FMC_RST_FLASH;
			flash_reg[1] <= `FMC_RST_FLASH;
			torch_reg[0] <= `FMC_RST_TORCH;
			torch_reg[1] <= `FMC_RST_TORCH;
			boost_reg    <= `FMC_RST_BOOST;
			timing_reg   <= `FMC_RST_TIMING;
		end else begin
			if (wr_ok) begin
				case (aw_idx_reg)
					`FMC_IDX_ENABLE: enable_reg   <= w_data_reg;
					`FMC_IDX_DROOP:  droop_reg    <= w_data_reg;
					`FMC_IDX_FLASH1: flash_reg[0] <= w_data_reg;
					`FMC_IDX_FLASH2: flash_reg[1] <= w_data_reg;
					`FMC_IDX_TORCH1: torch_reg[0] <= w_data_reg;
					`FMC_IDX_TORCH2: torch_reg[1] <= w_data_reg;
					`FMC_IDX_BOOST:  boost_reg    <= w_data_reg;
					`FMC_IDX_TIMING: timing_reg   <= w_data_reg;
					default: ;
				endcase
			end
			if (tout_event) begin
				enable_reg[`FMC_EN_MODE_HI:`FMC_EN_MODE_LO] <= `FMC_MODE_STANDBY;
			end
		end
	end

	// Software reset strobe lasts one cycle, bit itself never stays set
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			swrst_reg <= 1'b0;
		end else begin
			swrst_reg <= wr_ok & (aw_idx_reg == `FMC_IDX_BOOST) & w_data_reg[`FMC_BOOST_SWRST];
		end
	end

	// Sticky flags; a new event wins over the read clear
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			flag_tout_reg  <= 1'b0;
			flag_droop_reg <= 1'b0;
		end else if (soft_clr) begin
			flag_tout_reg  <= 1'b0;
			flag_droop_reg <= 1'b0;
		end else begin
			flag_tout_reg  <= tout_event | (flag_tout_reg & ~rd_clr1);
			flag_droop_reg <= droop_rise | (flag_droop_reg & ~rd_clr2);
		end
	end

	// Mode selection
	assign mode = enable_reg[`FMC_EN_MODE_HI:`FMC_EN_MODE_LO];

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			fmc_st_standby: begin
				if (mode == `FMC_MODE_FLASH) begin
					state_next = fmc_st_flash;
				end else if (mode == `FMC_MODE_TORCH) begin
					state_next = fmc_st_torch;
				end else if (mode == `FMC_MODE_IR && enable_reg[`FMC_EN_STROBE_BIT] && trig_rise) begin
					state_next = fmc_st_ir;
				end else if (mode == `FMC_MODE_STANDBY && trig_rise) begin
					// Strobe enable is checked first so both enables give a flash
					if (enable_reg[`FMC_EN_STROBE_BIT]) begin
						state_next = fmc_st_flash;
					end else if (enable_reg[`FMC_EN_TORCH_BIT]) begin
						state_next = fmc_st_torch;
					end
				end
			end
			fmc_st_torch: begin
				// No timeout and no sync term here
				if (ext_reg ? ~trig_s : (mode != `FMC_MODE_TORCH)) begin
					state_next = fmc_st_standby;
				end
			end
			fmc_st_flash: begin
				if (tout_hit || (ext_reg ? ~trig_s : (mode != `FMC_MODE_FLASH))) begin
					state_next = fmc_st_standby;
				end
			end
			fmc_st_ir: begin
				// Pulse width is the pin level, capped by the timeout
				if (tout_hit || ~trig_s || mode != `FMC_MODE_IR ||
						~enable_reg[`FMC_EN_STROBE_BIT]) begin
					state_next = fmc_st_standby;
				end
			end
			default: state_next = fmc_st_standby;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= fmc_st_standby;
			ext_reg   <= 1'b0;
		end else if (soft_clr) begin
			state_reg <= fmc_st_standby;
			ext_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == fmc_st_standby) begin
				ext_reg <= (mode == `FMC_MODE_STANDBY);
			end
		end
	end

	// Timeout counts whole milliseconds, also while sync forces torch level
	assign run_tout   = (state_reg == fmc_st_flash) | (state_reg == fmc_st_ir);
	assign tout_ms    = `FMC_TOUT_MIN_MS +
		11'(timing_reg[`FMC_TIM_TOUT_HI:`FMC_TIM_TOUT_LO]) * `FMC_TOUT_STEP_MS;
	assign tout_hit   = run_tout & (ms_cnt_reg >= tout_ms);
	assign tout_event = tout_hit & ~soft_clr;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ms_pre_reg <= 32'h0000_0000;
			ms_cnt_reg <= 11'h000;
		end else if (!run_tout || soft_clr) begin
			ms_pre_reg <= 32'h0000_0000;
			ms_cnt_reg <= 11'h000;
		end else if (ms_pre_reg == 32'(MS_CYCLES - 1)) begin
			ms_pre_reg <= 32'h0000_0000;
			ms_cnt_reg <= ms_cnt_reg + 11'h001;
		end else begin
			ms_pre_reg <= ms_pre_reg + 32'h0000_0001;
		end
	end

	// Ramp step tick; free running so the first step comes within one period
	assign ramp_period = 16'(RAMP_BASE_CYCLES *
		(int'(timing_reg[`FMC_TIM_RAMP_HI:`FMC_TIM_RAMP_LO]) + 1));
	assign ramp_step   = (ramp_cnt_reg >= ramp_period - 16'h0001);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ramp_cnt_reg <= 16'h0000;
		end else if (ramp_step) begin
			ramp_cnt_reg <= 16'h0000;
		end else begin
			ramp_cnt_reg <= ramp_cnt_reg + 16'h0001;
		end
	end

	// Sync input forces torch level only in flash and only when enabled
	assign tx_force = (state_reg == fmc_st_flash) & enable_reg[`FMC_EN_TX_BIT] & sync_s;

	// Droop during a flash freezes the ramp until the flash ends, except while sync forces torch level
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			hold_reg <= 1'b0;
		end else if (state_reg != fmc_st_flash || soft_clr) begin
			hold_reg <= 1'b0;
		end else if (droop_s) begin
			hold_reg <= 1'b1;
		end
	end

	// Pass-only choice is frozen while the converter runs
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pass_only_reg <= 1'b0;
			scale_d_reg   <= 1'b0;
		end else begin
			// Last force level; only a sync change may jump, flash entry with sync low still ramps
			scale_d_reg <= tx_force;
			if (soft_clr || state_reg == fmc_st_standby) begin
				pass_only_reg <= soft_clr ? 1'b0 : boost_reg[`FMC_BOOST_PASS];
			end
		end
	end

	// One current stepper per channel
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			fmc_led_t tgt;
			logic     use_torch;
			assign use_torch     = (state_reg == fmc_st_torch) | tx_force;
			assign tgt.code      = use_torch ? torch_reg[ch] : flash_reg[ch];
			assign tgt.flash_scale = ~use_torch;
			fmc_ramp u_ramp (
				.clk_in   (clk_in),
				.rst_in   (rst_in),
				.active_in(enable_reg[ch] & (state_reg != fmc_st_standby) & ~soft_clr),
				.jump_in  ((state_reg == fmc_st_ir) |
					(scale_d_reg != tx_force)),
				.hold_in  (hold_reg & ~tx_force),
				.step_in  (ramp_step),
				.target_in(tgt),
				.led_out  (led_out[ch])
			);
		end
	endgenerate

	// Converter on outside standby, pass-only also in infrared; other converter and comparator settings straight from registers
	assign boost_on_out        = (state_reg != fmc_st_standby);
	assign pass_only_out       = pass_only_reg | (state_reg == fmc_st_ir);
	assign droop_threshold_out = droop_reg[`FMC_DROOP_THR_HI:`FMC_DROOP_THR_LO];
	assign droop_hyst_out      = droop_reg[`FMC_DROOP_HYST_BIT];
	assign freq_high_out       = boost_reg[`FMC_BOOST_FREQ];
	assign ilim_high_out       = boost_reg[`FMC_BOOST_ILIM];
endmodule
`default_nettype wire

// ===== verif/fmc_checker.sv
`default_nettype none
module fmc_checker
	import fmc_pkg::*;
(
	input wire logic            clk_in,
	input wire logic            rst_in,
	input wire logic            s_axi_awready_out,
	input wire logic            s_axi_wready_out,
	input wire logic            s_axi_bvalid_out,
	input wire logic            s_axi_bready_in,
	input wire logic     [1:0]  s_axi_bresp_out,
	input wire logic            s_axi_arready_out,
	input wire logic            s_axi_rvalid_out,
	input wire logic            s_axi_rready_in,
	input wire logic     [31:0] s_axi_rdata_out,
	input wire logic            por_below_in,
	input wire fmc_led_t [1:0]  led_out,
	input wire logic            boost_on_out,
	input wire logic            pass_only_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// Supply fail held long enough to pass the synchroniser
	sequence s_por_held;
		por_below_in [*5];
	endsequence
	// Mode gone for long enough that the registered current must follow
	sequence s_idle_long;
		!boost_on_out [*3];
	endsequence

	property p_bresp_hold;
		s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
	endproperty
	property p_rdata_hold;
		s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
	endproperty
	property p_rdata_byte;
		s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0;
	endproperty
	property p_wr_block;
		s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
	endproperty
	property p_rd_block;
		s_axi_rvalid_out |-> !s_axi_arready_out;
	endproperty
	property p_por_clear;
		s_por_held |-> led_out == 18'h0 && !boost_on_out;
	endproperty
	property p_idle_dark;
		s_idle_long |-> led_out == 18'h0;
	endproperty
	// Pass-only covers the infrared jump, a scale change covers sync
	property p_ramp_step;
		!pass_only_out && $stable(led_out[0].flash_scale)
			&& led_out[0].code > $past(led_out[0].code)
			|-> led_out[0].code == $past(led_out[0].code) + 8'h1;
	endproperty

	a_bresp_hold: assert property (p_bresp_hold) else $error("write answer not held");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read answer not held");
	a_rdata_byte: assert property (p_rdata_byte) else $error("upper read bits set");
	a_wr_block: assert property (p_wr_block) else $error("write taken during response");
	a_rd_block: assert property (p_rd_block) else $error("read taken during response");
	a_por_clear: assert property (p_por_clear) else $error("current on under supply fail");
	a_idle_dark: assert property (p_idle_dark) else $error("current on without a mode");
	a_ramp_step: assert property (p_ramp_step) else $error("ramp skipped a level");
endmodule

bind fmc_top fmc_checker i_chk (.clk_in, .rst_in, .s_axi_awready_out, .s_axi_wready_out,
	.s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arready_out,
	.s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .por_below_in, .led_out,
	.boost_on_out, .pass_only_out);
`default_nettype wire

// ===== verif/fmc_pin_model.sv
`default_nettype none
module fmc_pin_model (
	output logic trigger_out,
	output logic sync_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic lclk = 1'b0;

	// Released pins sit at their pull-down level
	initial begin
		trigger_out = 1'b0;
		sync_out = 1'b0;
	end
	// Camera-side clock, offset so its edges never fall on a core clock edge
	initial begin
		#3;
		forever #40 lclk = ~lclk;
	end
	task drive(input logic t, input logic s);
		@(posedge lclk);
		trigger_out <= t;
		sync_out <= s;
	endtask
	// One infrared period in camera cycles; 125 cycles is the fastest legal rate
	task ir_pulse(input int hi, input int per);
		drive(1'b1, 1'b0);
		repeat (hi) @(posedge lclk);
		drive(1'b0, 1'b0);
		repeat (per - hi - 1) @(posedge lclk);
	endtask
endmodule
`default_nettype wire

// ===== verif/fmc_top_bench.sv
`default_nettype none
`include "fmc_consts.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
	$display("Error at %0t: got %h want %h", $time, a, b); end end
`define WAITF(c, l) begin for (n = 0; n < l; n++) begin @(negedge clk_in); if (c) break; end \
	if (!(c)) begin num_errors++; $display("Error at %0t: wait ran out", $time); results(); end end
module fmc_top_bench
	import fmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 20;
	localparam int RB = 2;
	logic clk_in = 1'b0, rst_in = 1'b1, por = 1'b0, drp = 1'b0;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic [7:0] aadr = 8'h0, radr = 8'h0, tgt, tq;
	logic [31:0] wdat = 32'h0, dat;
	logic [3:0] wstb = 4'h0;
	logic [1:0] rsp;
	wire logic awr, wr, bv, arr, rv, boost, pass, hyst, freq, ilim, trig, sync;
	wire logic [1:0] br, rr;
	wire logic [31:0] rd;
	wire logic [2:0] thr;
	fmc_led_t [1:0] led;
	fmc_led_t exp;
	int mdl [16];
	int num_errors = 0, checks = 0, n, seed = 32'hfbd0b979;
	time t0;

	fmc_top #(.MS_CYCLES(MS), .RAMP_BASE_CYCLES(RB)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(aadr),
		.s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_wdata_in(wdat), .s_axi_wstrb_in(wstb),
		.s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_bresp_out(br),
		.s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(radr),
		.s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
		.trigger_pin_in(trig), .sync_pin_in(sync), .por_below_in(por), .droop_below_in(drp),
		.led_out(led), .boost_on_out(boost), .pass_only_out(pass), .droop_threshold_out(thr),
		.droop_hyst_out(hyst), .freq_high_out(freq), .ilim_high_out(ilim));
	fmc_pin_model pins (.trigger_out(trig), .sync_out(sync));

	// Core clock
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	task results;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Register image after any reset
	function void mdl_reset;
		foreach (mdl[k]) mdl[k] = 0;
		mdl[1] = 8'h80;
		mdl[8] = 8'h1a;
	endfunction
	// Bits that random writes may touch without side effects
	function logic [7:0] msk(input int k);
		return k == 2 ? 8'h3c : k == 7 ? 8'h07 : k == 8 ? 8'h7f : 8'hff;
	endfunction
	task wreg(input logic [5:0] i, input logic [7:0] d);
		logic ga, gw;
		@(posedge clk_in);
		awv <= 1'b1; wv <= 1'b1; bre <= 1'b1; aadr <= {i, 2'b00}; wdat <= {24'h0, d}; wstb <= 4'hf;
		ga = 1'b0;
		gw = 1'b0;
		for (n = 0; n < 40 && !(ga && gw); n++) begin
			@(negedge clk_in);
			if (awr && awv) ga = 1'b1;
			if (wr && wv) gw = 1'b1;
			@(posedge clk_in);
			if (ga) awv <= 1'b0;
			if (gw) wv <= 1'b0;
		end
		`WAITF(bv, 40)
		rsp = br;
		@(posedge clk_in);
		bre <= 1'b0;
		if (i == 6'h07 && d[7]) mdl_reset();
		else if (i >= 6'h01 && i <= 6'h08) mdl[i] = d;
	endtask
	task rreg(input logic [5:0] i);
		@(posedge clk_in);
		arv <= 1'b1; rre <= 1'b1; radr <= {i, 2'b00};
		`WAITF(arr, 40)
		@(posedge clk_in);
		arv <= 1'b0;
		`WAITF(rv, 40)
		dat = rd;
		rsp = rr;
		@(posedge clk_in);
		rre <= 1'b0;
	endtask
	task chk_all;
		for (int k = 1; k <= 8; k++) begin
			rreg(6'(k));
			`CHK(dat, mdl[k])
		end
	endtask
	task settle(input int c);
		repeat (c) @(posedge clk_in);
	endtask

	initial begin
		mdl_reset();
		settle(6);
		rst_in <= 1'b0;
		settle(2 * MS);
		chk_all();
		for (int k = 2; k <= 8; k++) begin
			dat = $random(seed);
			wreg(6'(k), dat[7:0] & msk(k));
			`CHK(rsp, `FMC_RESP_OKAY)
		end
		chk_all();
		`CHK({thr, hyst}, mdl[2][5:2])
		`CHK({pass, freq, ilim}, mdl[7][2:0])
		wreg(6'h3f, 8'h55);
		`CHK(rsp, `FMC_RESP_SLVERR)
		rreg(6'h3f);
		`CHK(rsp, `FMC_RESP_SLVERR)
		wreg(6'h0a, 8'hff);
		`CHK(rsp, `FMC_RESP_OKAY)
		wreg(6'h07, 8'h80);
		settle(2 * MS);
		chk_all();
		// Internal flash with sync toggled, then left to time out
		dat = $random(seed);
		tgt = {3'b0, dat[4:0]} + 8'h08;
		tq = {3'b0, dat[9:5]} + 8'h04;
		wreg(6'h03, tgt);
		wreg(6'h05, tq);
		wreg(6'h08, 8'h00);
		wreg(6'h01, 8'h8f);
		t0 = $time;
		`WAITF(led[0].code == tgt, 200)
		`CHK(led[0].flash_scale, 1'b1)
		`CHK(n >= RB * tgt - 8, 1'b1)
		pins.drive(1'b0, 1'b1);
		settle(8);
		`CHK(led[0], {tq, 1'b0})
		pins.drive(1'b0, 1'b0);
		settle(8);
		`CHK(led[0], {tgt, 1'b1})
		`WAITF(!boost, 1200)
		`CHK(($time - t0) / 10 inside {[40 * MS - 10:40 * MS + 10]}, 1'b1)
		rreg(6'h0a);
		`CHK(dat, 32'h1)
		rreg(6'h0a);
		`CHK(dat, 32'h0)
		mdl[1] = 8'h83;
		rreg(6'h01);
		`CHK(dat, mdl[1])
		// Internal torch outlives the timeout with sync held high
		pins.drive(1'b0, 1'b1);
		wreg(6'h01, 8'h8b);
		settle(1000);
		`CHK({boost, led[0]}, {1'b1, tq, 1'b0})
		pins.drive(1'b0, 1'b0);
		wreg(6'h01, 8'h80);
		// Trigger pin with both enables, then torch enable alone
		for (int k = 0; k < 2; k++) begin
			wreg(6'h01, k ? 8'h93 : 8'hb3);
			exp = k ? {tq, 1'b0} : {tgt, 1'b1};
			pins.drive(1'b1, 1'b0);
			`WAITF(led[0] == exp, 200)
			`CHK(led[0], exp)
			pins.drive(1'b0, 1'b0);
			`WAITF(!boost, 20)
		end
		// Infrared level pulses and an overlong one
		wreg(6'h01, 8'ha7);
		pins.drive(1'b1, 1'b0);
		settle(6);
		`CHK({pass, led[0]}, {1'b1, tgt, 1'b1})
		pins.drive(1'b0, 1'b0);
		settle(6);
		`CHK(led[0], 9'h0)
		repeat (2) pins.ir_pulse(20, 125);
		pins.drive(1'b1, 1'b0);
		`WAITF(led[0].code == tgt, 20)
		`CHK(led[0].code, tgt)
		`WAITF(led[0].code == 8'h0, 1200)
		rreg(6'h0a);
		`CHK(dat, 32'h1)
		pins.drive(1'b0, 1'b0);
		// Sync ignored once its enable is clear
		wreg(6'h01, 8'h0f);
		`WAITF(led[0].code == tgt, 200)
		pins.drive(1'b0, 1'b1);
		settle(8);
		`CHK(led[0], {tgt, 1'b1})
		pins.drive(1'b0, 1'b0);
		wreg(6'h01, 8'h80);
		@(posedge clk_in) drp <= 1'b1;
		settle(4);
		rreg(6'h0b);
		`CHK(dat, 32'h1)
		@(posedge clk_in) drp <= 1'b0;
		// Droop in a slow flash ramp freezes the level
		wreg(6'h08, 8'h70);
		wreg(6'h01, 8'h0f);
		settle(40);
		@(posedge clk_in) drp <= 1'b1;
		settle(20);
		tq = led[0].code;
		settle(100);
		`CHK(led[0].code, tq)
		@(posedge clk_in) drp <= 1'b0;
		@(posedge clk_in) por <= 1'b1;
		settle(8);
		por <= 1'b0;
		mdl_reset();
		settle(2 * MS);
		chk_all();
		results();
	end
endmodule
`default_nettype wire
